// File: design/self_program_map.svh
`ifndef SELF_PROGRAM_MAP_SVH
`define SELF_PROGRAM_MAP_SVH

// Word address width of the whole flash
`define FLASH_ADDR_W      13
// First word address of the halting section (fixed, independent of fuses)
`define HALT_SECT_START   13'h1c00
// Boot section sizes in words per boot size fuse code 2'b11..2'b00
`define BOOT_WORDS_3      13'h0080
`define BOOT_WORDS_2      13'h0100
`define BOOT_WORDS_1      13'h0200
`define BOOT_WORDS_0      13'h0400
// Page erase or write time in ns and its cycle count at 25 MHz
`define PAGE_OP_NS        4000
`define CLK_PERIOD_NS     40
`define PAGE_OP_CYCLES    ((`PAGE_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Lock bit reset values (unprogrammed)
`define LOCK_RESET        2'h3

`endif

// File: design/self_program_pkg.sv
package self_program_pkg;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ERASE,
        OP_WRITE,
        OP_LOAD
    } prog_op_e;

    typedef struct packed {
        logic        valid;
        prog_op_e    op;
        logic [12:0] fetchPc;
        logic [12:0] target;
    } store_req_s;

    typedef struct packed {
        logic [1:0] appLock;
        logic [1:0] bootLock;
    } lock_set_s;

endpackage

// File: design/page_op_timer.sv
`include "self_program_map.svh"

module page_op_timer #(
    parameter int CYCLES = `PAGE_OP_CYCLES
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      running,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_done;

    always_comb begin
        next_count = count;
        next_done  = 1'b0;
        if (start && count == '0) begin
            next_count = CW'(CYCLES);
        end else if (count != '0) begin
            next_count = count - CW'(1);
            next_done  = (count == CW'(1));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            done  <= next_done;
        end
    end

    assign running = (count != '0);

endmodule

// File: design/self_program_section_control.sv
// Summary of operation
// - A store-program erase or write starts only when issued from the boot loader section.
// - From the boot loader section any page of the flash may be targeted, boot pages included.
// - Boot section size follows the boot size fuses; the halting section boundary is fixed.
// - Application pages are guarded by the first lock set, boot pages by the second.
// - The two lock sets are written independently and never disturb each other.
// - Programming a concurrent-read page leaves the CPU running and serving halting-section reads.
// - Programming a halting-section page stalls the CPU for the whole page operation.
// - While the concurrent-read section is programmed no valid code comes from it.
// - The boot loader section always lies inside the halting section.
// - The section busy flag reads one while the concurrent-read section is blocked.
// - The busy flag is set when a concurrent-read page erase or write starts.
// - The busy flag clears on a read re-enable write after completion or when a page load starts.
`include "self_program_map.svh"

module self_program_section_control #(
    parameter int OP_CYCLES = `PAGE_OP_CYCLES
) (
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire self_program_pkg::store_req_s storeReq,
    input  wire logic [1:0]                  boot_size_fuses,
    input  wire logic                        lockWrite,
    input  wire self_program_pkg::lock_set_s lockData,
    input  wire logic                        section_read_reenable,
    input  wire logic [12:0]                 readAddr,
    output logic                             section_busy_flag,
    output logic                             cpuStall,
    output logic                             readBlocked,
    output logic                             progStart,
    output logic                             progRefused,
    output self_program_pkg::lock_set_s      lockState
);
    import self_program_pkg::*;

    // ****************************************************
    // Section decode
    // ****************************************************
    logic [12:0] bootWords;
    logic [12:0] bootStart;
    logic        pcInBoot;
    logic        tgtInBoot;
    logic        tgtInHalt;
    logic        isPageOp;
    logic        allowed;

    always_comb begin
        case (boot_size_fuses)
            2'h3:    bootWords = `BOOT_WORDS_3;
            2'h2:    bootWords = `BOOT_WORDS_2;
            2'h1:    bootWords = `BOOT_WORDS_1;
            default: bootWords = `BOOT_WORDS_0;
        endcase
    end

    // Boot section sits at the top, largest size starting right at the fixed boundary
    assign bootStart = 13'h0000 - bootWords;
    assign pcInBoot  = storeReq.fetchPc >= bootStart;
    assign tgtInBoot = storeReq.target >= bootStart;
    assign tgtInHalt = storeReq.target >= `HALT_SECT_START;
    assign isPageOp  = storeReq.valid && (storeReq.op == OP_ERASE || storeReq.op == OP_WRITE);

    // Lock code 2'b11 or 2'b01 lets store-program write the section
    always_comb begin
        allowed = 1'b0;
        if (isPageOp && pcInBoot) begin
            if (tgtInBoot) begin
                allowed = lockState.bootLock[0];
            end else begin
                allowed = lockState.appLock[0];
            end
        end
    end

    // ****************************************************
    // Page operation timing
    // ****************************************************
    logic opRunning;
    logic opDone;
    logic opStart;

    page_op_timer #(
        .CYCLES (OP_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (opStart),
        .running (opRunning),
        .done    (opDone)
    );

    // ****************************************************
    // Control state
    // ****************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONC,
        ST_HALT
    } phase_e;

    phase_e    phase;
    phase_e    next_phase;
    logic      next_busy;
    logic      next_stall;
    logic      next_blocked;
    logic      next_start;
    logic      next_refused;
    lock_set_s next_lock;

    // The timer goes idle one cycle before the phase does; gating on the phase
    // keeps a request in that gap from starting a timer that no phase follows
    assign opStart = allowed && !opRunning && phase == ST_IDLE;

    always_comb begin
        next_phase   = phase;
        next_busy    = section_busy_flag;
        next_stall   = cpuStall;
        next_start   = 1'b0;
        next_refused = isPageOp && !opStart;
        next_lock    = lockState;
        if (lockWrite) begin
            // Lock bits only go programmed; each set written alone
            next_lock.appLock  = lockState.appLock & lockData.appLock;
            next_lock.bootLock = lockState.bootLock & lockData.bootLock;
        end
        case (phase)
            ST_IDLE: begin
                if (opStart) begin
                    next_start = 1'b1;
                    if (tgtInHalt) begin
                        next_phase = ST_HALT;
                        next_stall = 1'b1;
                    end else begin
                        next_phase = ST_CONC;
                        next_busy  = 1'b1;
                    end
                end
            end
            ST_CONC: begin
                if (opDone) begin
                    next_phase = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (opDone) begin
                    // Stall drops once; the core holds its next pc meanwhile
                    next_phase = ST_IDLE;
                    next_stall = 1'b0;
                end
            end
            default: next_phase = ST_IDLE;
        endcase
        // Clearing waits for completion, so a request mid-operation is ignored
        if (phase == ST_IDLE && !opStart) begin
            if (section_read_reenable) begin
                next_busy = 1'b0;
            end
            if (storeReq.valid && storeReq.op == OP_LOAD) begin
                next_busy = 1'b0;
            end
        end
        next_blocked = next_busy && (readAddr < `HALT_SECT_START);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase             <= ST_IDLE;
            section_busy_flag <= 1'b0;
            cpuStall          <= 1'b0;
            readBlocked       <= 1'b0;
            progStart         <= 1'b0;
            progRefused       <= 1'b0;
            lockState         <= '{appLock: `LOCK_RESET, bootLock: `LOCK_RESET};
        end else begin
            phase             <= next_phase;
            section_busy_flag <= next_busy;
            cpuStall          <= next_stall;
            readBlocked       <= next_blocked;
            progStart         <= next_start;
            progRefused       <= next_refused;
            lockState         <= next_lock;
        end
    end

    // ****************************************************
    // Stall length watch
    // ****************************************************
    // A counter rather than a long repetition keeps the stall bound cheap to check
    localparam int SCW = $clog2(OP_CYCLES + 3);

    logic [SCW-1:0] stallCount;
    logic [SCW-1:0] next_stallCount;

    always_comb begin
        next_stallCount = '0;
        if (cpuStall) begin
            next_stallCount = stallCount;
            if (stallCount != '1) begin
                next_stallCount = stallCount + SCW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stallCount <= '0;
        end else begin
            stallCount <= next_stallCount;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    a_app_no_start: assert property (@(posedge mclk) disable iff (sys_rst)
        isPageOp && !pcInBoot |=> !progStart)
        else $error("page op from application section started");
    a_boot_starts: assert property (@(posedge mclk) disable iff (sys_rst)
        isPageOp && pcInBoot && !opRunning && lockState == 4'hf && phase == ST_IDLE |=> progStart)
        else $error("allowed boot page op did not start");
    a_boot_in_halt: assert property (@(posedge mclk) disable iff (sys_rst)
        bootStart >= `HALT_SECT_START)
        else $error("boot section outside halting section");
    a_conc_no_stall: assert property (@(posedge mclk) disable iff (sys_rst)
        progStart && phase == ST_CONC |-> !cpuStall)
        else $error("cpu stalled for concurrent section op");
    a_halt_stall: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_HALT |-> cpuStall)
        else $error("stall dropped during halting op");
    a_busy_set: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(phase == ST_CONC) |-> section_busy_flag)
        else $error("busy flag not set on concurrent op");
    a_busy_blocks: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_CONC |-> section_busy_flag)
        else $error("busy flag low while section blocked");
    a_load_clears: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_IDLE && !opStart && storeReq.valid && storeReq.op == OP_LOAD |=> !section_busy_flag)
        else $error("page load did not clear busy");
    a_lock_indep: assert property (@(posedge mclk) disable iff (sys_rst)
        lockWrite && lockData.bootLock == 2'h3 |=> lockState.bootLock == $past(lockState.bootLock))
        else $error("boot lock changed by app lock write");
    a_stall_release: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_HALT && opDone |=> !cpuStall)
        else $error("stall not released");


    // Stall, read gating and busy flag
    // Stall spans the page operation plus the cycle that registers its end
    a_stall_length: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(cpuStall) |-> stallCount == SCW'(OP_CYCLES + 1))
        else $error("halting stall length wrong");
    a_idle_no_stall: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_IDLE |-> !cpuStall)
        else $error("stall held while idle");
    a_conc_running: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_CONC |-> !cpuStall)
        else $error("cpu stalled during concurrent op");
    a_blocked_busy: assert property (@(posedge mclk) disable iff (sys_rst)
        readBlocked |-> section_busy_flag)
        else $error("read blocked without busy flag");
    a_blocked_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        readBlocked |-> $past(readAddr) < `HALT_SECT_START)
        else $error("halting section read blocked");
    a_conc_blocked: assert property (@(posedge mclk) disable iff (sys_rst)
        section_busy_flag && $past(readAddr) < `HALT_SECT_START |-> readBlocked)
        else $error("busy section read not blocked");
    a_busy_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        phase != ST_IDLE && section_busy_flag |=> section_busy_flag)
        else $error("busy flag cleared during op");
    a_reenable_clears: assert property (@(posedge mclk) disable iff (sys_rst)
        phase == ST_IDLE && !opStart && section_read_reenable |=> !section_busy_flag)
        else $error("read re-enable did not clear busy");

    // Refusal, locks and start
    a_refuse_app: assert property (@(posedge mclk) disable iff (sys_rst)
        isPageOp && !pcInBoot |=> progRefused)
        else $error("application page op not refused");
    a_refuse_busy: assert property (@(posedge mclk) disable iff (sys_rst)
        isPageOp && phase != ST_IDLE |=> progRefused && !progStart)
        else $error("page op accepted while another runs");
    a_start_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        progStart |=> !progStart)
        else $error("start pulse repeated");
    a_boot_target: assert property (@(posedge mclk) disable iff (sys_rst)
        isPageOp && pcInBoot && tgtInBoot && lockState.bootLock[0] && phase == ST_IDLE && !opRunning |=> progStart)
        else $error("boot page op refused");
    a_halt_target: assert property (@(posedge mclk) disable iff (sys_rst)
        progStart && $past(storeReq.target) >= `HALT_SECT_START |-> cpuStall)
        else $error("halting page op without stall");
    a_conc_target: assert property (@(posedge mclk) disable iff (sys_rst)
        progStart && $past(storeReq.target) < `HALT_SECT_START |-> section_busy_flag && !cpuStall)
        else $error("concurrent page op handled wrongly");
    a_app_lock_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        lockWrite && lockData.appLock == 2'h3 |=> lockState.appLock == $past(lockState.appLock))
        else $error("app lock changed by boot lock write");
    a_lock_mono: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1 |=> (lockState & $past(lockState)) == lockState)
        else $error("lock bit returned to unprogrammed");

    c_conc_op: cover property (@(posedge mclk) disable iff (sys_rst) progStart && !cpuStall);
    c_halt_op: cover property (@(posedge mclk) disable iff (sys_rst) progStart && cpuStall);
    c_refused: cover property (@(posedge mclk) disable iff (sys_rst) progRefused);
    c_reenable: cover property (@(posedge mclk) disable iff (sys_rst) $fell(section_busy_flag));
    c_load_clear: cover property (@(posedge mclk) disable iff (sys_rst) storeReq.valid && storeReq.op == OP_LOAD && section_busy_flag);

endmodule

// File: tb/cpu_model.sv
module cpu_model (
    input  wire logic                   mclk,
    input  wire logic                   cpuStall,
    output self_program_pkg::store_req_s storeReq,
    output logic [12:0]                 readAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    import self_program_pkg::*;
    // ********************
    // Core request side
    // ********************
    initial begin
        storeReq = '0;
        readAddr = 13'h0000;
    end
    // A stalled core issues nothing; requests last exactly one cycle
    task automatic issue(input prog_op_e op, input logic [12:0] pc, input logic [12:0] tgt, output logic stuck);
        int n;
        n = 0;
        while (cpuStall === 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        stuck = (n == 300);
        @(posedge mclk);
        storeReq <= '{1'b1, op, pc, tgt};
        @(posedge mclk);
        storeReq.valid <= 1'b0;
    endtask
    // Drive the read address at the next clock edge, whether busy is set or not
    task automatic fetch(input logic [12:0] a);
        @(posedge mclk);
        readAddr <= a;
    endtask
endmodule

// File: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import self_program_pkg::*;
    localparam int OPC = 4;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  fuses = 2'h3;
    logic        lockWrite = 1'b0;
    lock_set_s   lockData = '1;
    logic        reenable = 1'b0;
    store_req_s  storeReq;
    logic [12:0] readAddr;
    logic        busy, cpuStall, readBlocked, progStart, progRefused;
    lock_set_s   lockState;
    int          failures = 0;
    int          checks = 0;
    always #20 mclk = ~mclk;
    cpu_model u_cpu_model (.mclk(mclk), .cpuStall(cpuStall), .storeReq(storeReq), .readAddr(readAddr));
    self_program_section_control #(.OP_CYCLES(OPC)) u_self_program_section_control (
        .mclk(mclk), .sys_rst(sys_rst), .storeReq(storeReq), .boot_size_fuses(fuses),
        .lockWrite(lockWrite), .lockData(lockData), .section_read_reenable(reenable),
        .readAddr(readAddr), .section_busy_flag(busy), .cpuStall(cpuStall),
        .readBlocked(readBlocked), .progStart(progStart), .progRefused(progRefused),
        .lockState(lockState));
    // ********************
    // Helpers
    // ********************
    task automatic summarize();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Issue one request and check which answer pulse comes back
    task automatic req(input prog_op_e op, input logic [12:0] pc, input logic [12:0] tgt, input logic ok);
        int   n;
        logic stuck;
        u_cpu_model.issue(op, pc, tgt, stuck);
        if (stuck) begin
            failures++;
            summarize();
        end
        #1;
        n = 0;
        while (progStart !== 1'b1 && progRefused !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        if (n == 4 && op != OP_LOAD) begin
            failures++;
            summarize();
        end
        if (op != OP_LOAD) chk("progStart", {3'h0, ok}, {3'h0, progStart});
        if (op != OP_LOAD) chk("progRefused", {3'h0, !ok}, {3'h0, progRefused});
    endtask
    task automatic pulse_reenable();
        @(posedge mclk);
        reenable <= 1'b1;
        @(posedge mclk);
        reenable <= 1'b0;
        tick(1);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_app_refused();
        req(OP_ERASE, 13'h0010, 13'h0100, 1'b0);
        tick(1);
        chk("busyApp", 4'h0, {3'h0, busy});
    endtask
    task automatic t_rww_write();
        req(OP_WRITE, 13'h1f80, 13'h0100, 1'b1);
        chk("busySet", 4'h1, {3'h0, busy});
        chk("noStall", 4'h0, {3'h0, cpuStall});
        req(OP_WRITE, 13'h1f80, 13'h0200, 1'b0);
        u_cpu_model.fetch(13'h0100);
        tick(2);
        chk("rwwBlocked", 4'h1, {3'h0, readBlocked});
        u_cpu_model.fetch(13'h1c00);
        tick(2);
        chk("nrwwReadable", 4'h0, {3'h0, readBlocked});
        tick(OPC + 4);
        chk("busyHolds", 4'h1, {3'h0, busy});
        pulse_reenable();
        chk("busyCleared", 4'h0, {3'h0, busy});
    endtask
    task automatic t_halting_section_erase();
        int n;
        req(OP_ERASE, 13'h1f80, 13'h1f80, 1'b1);
        chk("stallOn", 4'h1, {3'h0, cpuStall});
        chk("busyNrww", 4'h0, {3'h0, busy});
        n = 0;
        while (cpuStall === 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (n == 50) begin
            failures++;
            summarize();
        end
        chk("stallLen", 4'(OPC + 1), 4'(n));
    endtask
    // Lowest boot address per fuse code; below it the core runs application code
    task automatic t_fuses();
        logic [12:0] bs [4] = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
        for (int f = 0; f < 4; f++) begin
            @(posedge mclk);
            fuses <= 2'(f);
            tick(1);
            req(OP_ERASE, bs[f] - 13'h0001, 13'h0000, 1'b0);
            req(OP_ERASE, bs[f], 13'h0000, 1'b1);
            tick(OPC + 4);
            req(OP_LOAD, bs[f], 13'h0000, 1'b0);
            tick(1);
            chk("busyLoad", 4'h0, {3'h0, busy});
        end
    endtask
    task automatic t_locks();
        chk("lockReset", 4'hf, lockState);
        @(posedge mclk);
        lockWrite <= 1'b1;
        lockData <= '{2'h2, 2'h3};
        @(posedge mclk);
        lockWrite <= 1'b0;
        tick(1);
        chk("lockApp", 4'hb, lockState);
        req(OP_ERASE, 13'h1f80, 13'h0100, 1'b0);
        req(OP_ERASE, 13'h1f80, 13'h1f80, 1'b1);
        tick(OPC + 6);
        @(posedge mclk);
        lockWrite <= 1'b1;
        lockData <= '{2'h3, 2'h2};
        @(posedge mclk);
        lockWrite <= 1'b0;
        tick(1);
        chk("lockBoot", 4'ha, lockState);
        req(OP_ERASE, 13'h1f80, 13'h1f80, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        tick(1);
        t_app_refused();
        t_rww_write();
        t_halting_section_erase();
        t_fuses();
        t_locks();
        summarize();
    end
endmodule
